// ==== jisp_cells.sv ====
`timescale 1ns/1ps
// nonvolatile cell array with the complete bit above the last word
module jisp_cells #(parameter int AW = 5, parameter int DW = 16, parameter int DEPTH = 14)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic pgm_en,
   input wire logic ers_en,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DEPTH-1:0][DW-1:0] mem_q,
   output logic done_q
);
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] mem;
      logic done;
   } jisp_cell_st_t;
   jisp_cell_st_t q_r, q_nxt;

   // erase blanks all, a write after the complete bit drops it again
   always_comb
   begin
      q_nxt = q_r;
      if (ers_en)
      begin
         q_nxt.mem = {DEPTH{DW'(jisp_pkg::ERASE_WORD)}};
         q_nxt.done = 1'b0;
      end
      else if (pgm_en)
      begin
         if (addr == AW'(DEPTH))
            q_nxt.done = 1'b1;
         else if (addr < AW'(DEPTH))
         begin
            q_nxt.mem[addr] = wdata;
            q_nxt.done = 1'b0;
         end
      end
   end

   // reset stands for a blank part at power-up
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         q_r <= '{mem: {DEPTH{DW'(jisp_pkg::ERASE_WORD)}}, done: 1'b0};
      else
         q_r <= q_nxt;
   end

   assign mem_q = q_r.mem;
   assign done_q = q_r.done;
endmodule // jisp_cells

// ==== jisp_chk.sv ====
`timescale 1ns/1ps
// watches the top ports for the pin safety and test port rules
module jisp_chk #(parameter int PINS = 8)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdo_oe_n,
   input wire logic [PINS-1:0] pin_out,
   input wire logic [PINS-1:0] pin_oe_n,
   input wire logic [PINS-1:0] pin_pullup,
   input wire logic isp_active,
   input wire logic prog_complete
);
   // pins float with pull-ups while programming
   property p_isp_float;
      @(posedge mclk) disable iff (!resetn) isp_active |-> &pin_oe_n;
   endproperty
   a_isp_float: assert property (p_isp_float) else $error("pin driven while programming");
   property p_isp_pullup;
      @(posedge mclk) disable iff (!resetn) isp_active |-> &pin_pullup;
   endproperty
   a_isp_pullup: assert property (p_isp_pullup) else $error("pull-up missing while programming");
   // no driver until the complete bit is set
   property p_safe_until_done;
      @(posedge mclk) disable iff (!resetn) !prog_complete |-> &pin_oe_n;
   endproperty
   a_safe_until_done: assert property (p_safe_until_done) else $error("pin driven before complete");
   // user outputs ignored from the second cycle of programming on
   property p_user_ignored;
      @(posedge mclk) disable iff (!resetn) isp_active && $past(isp_active) |-> pin_out == '0;
   endproperty
   a_user_ignored: assert property (p_user_ignored) else $error("user output leaks in programming");
   // pull-ups released one cycle after leaving programming
   property p_pullup_release;
      @(posedge mclk) disable iff (!resetn) $fell(isp_active) |=> pin_pullup == '0;
   endproperty
   a_pullup_release: assert property (p_pullup_release) else $error("pull-ups kept after exit");
   // programming state lasts at least 8 core clocks once it starts
   property p_entry_hold;
      @(posedge mclk) disable iff (!resetn) $rose(isp_active) |-> isp_active [*8];
   endproperty
   a_entry_hold: assert property (p_entry_hold) else $error("programming state too short");
   // complete bit only moves inside programming mode
   property p_done_in_isp;
      @(posedge mclk) disable iff (!resetn) $changed(prog_complete) |-> $past(isp_active);
   endproperty
   a_done_in_isp: assert property (p_done_in_isp) else $error("complete bit moved in user mode");
   // data out enable follows the shift state
   property p_tdo_window;
      @(posedge tck) disable iff (!resetn) !tdo_oe_n |=> tdo_oe_n == $past(tms);
   endproperty
   a_tdo_window: assert property (p_tdo_window) else $error("data out enable off shift state");
endmodule // jisp_chk

// ==== jisp_pkg.sv ====
// How it works
// - programming reaches the device only through the four-pin test port
// - while programming, every user pin floats with its weak pull-up on
// - the complete bit is written last; until set, no output drives
// - device shifts read data out serially; programmer compares it
// - entry moves pins smoothly into programming state over 1 ms
// - erase instruction starts one 100 ms erase pulse, which the programmer waits out
// - program: address and data shifted in, then one program pulse per address
// - verify: address shifted in, read pulse, stored word shifted out
// - exit returns pins smoothly to user operation over 1 ms
// - device works with both adaptive and fixed-sequence programmers
// - user mode: pin control floats the output, enables it always, or takes a global enable
// - pin enable picks one of six or ten global enables from several sources
package jisp_pkg;
   // timing, as printed, and derived counts at the 250 MHz core clock
   localparam int unsigned MCLK_MHZ = 250;
   localparam int unsigned ENTER_TIME_MS = 1;
   localparam int unsigned EXIT_TIME_MS = 1;
   localparam int unsigned ERASE_TIME_MS = 100;
   localparam int unsigned PROG_PULSE_US = 10;
   localparam int unsigned READ_PULSE_US = 1;
   localparam int unsigned ENTER_CYC = ENTER_TIME_MS * 1000 * MCLK_MHZ;
   localparam int unsigned EXIT_CYC = EXIT_TIME_MS * 1000 * MCLK_MHZ;
   localparam int unsigned ERASE_CYC = ERASE_TIME_MS * 1000 * MCLK_MHZ;
   localparam int unsigned PROG_CYC = PROG_PULSE_US * MCLK_MHZ;
   localparam int unsigned READ_CYC = READ_PULSE_US * MCLK_MHZ;
   localparam int TMR_W = 25;
   // test port instructions
   localparam int IR_W = 4;
   localparam logic [3:0] IR_CAPT = 4'h1;
   localparam logic [3:0] IR_IDCODE = 4'h1;
   localparam logic [3:0] IR_ENTER = 4'h2;
   localparam logic [3:0] IR_EXIT = 4'h3;
   localparam logic [3:0] IR_ERASE = 4'h4;
   localparam logic [3:0] IR_PROG = 4'h5;
   localparam logic [3:0] IR_VERIFY = 4'h6;
   localparam logic [3:0] IR_ADDR = 4'h7;
   localparam logic [3:0] IR_DATA = 4'h8;
   localparam logic [3:0] IR_STATUS = 4'h9;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   // operations handed to the core clock domain
   localparam int OP_W = 3;
   localparam logic [2:0] OP_ENTER = 3'h0;
   localparam logic [2:0] OP_EXIT = 3'h1;
   localparam logic [2:0] OP_ERASE = 3'h2;
   localparam logic [2:0] OP_PROG = 3'h3;
   localparam logic [2:0] OP_READ = 3'h4;
   // cell word fields
   localparam int PM_LO = 0;
   localparam int PM_W = 2;
   localparam int PG_LO = 2;
   localparam int PG_W = 4;
   localparam int GS_LO = 0;
   localparam int GS_W = 5;
   localparam logic [1:0] PM_GND = 2'h0;
   localparam logic [1:0] PM_VCC = 2'h1;
   localparam logic [1:0] PM_GLB = 2'h2;
   localparam logic [15:0] ERASE_WORD = 16'hFFFF;
endpackage

// ==== jisp_prog.sv ====
`timescale 1ns/1ps
// external programmer; test clock stands still between frames
module jisp_prog
(
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one test clock period, data out taken before the rising edge
   task automatic tick(input logic m, input logic b, output logic q);
      tms = m;
      tdi = b;
      #16;
      q = tdo_oe_n ? ~tdo : tdo; // released line reads back inverted
      tck = 1'b1;
      #16;
      tck = 1'b0;
   endtask
   // walk to reset and park in idle
   task automatic reset_tap();
      logic q;
      for (int i = 0; i < 6; i++)
         tick(i < 5, ~tdi, q);
   endtask
   // idle clocks as a fixed wait
   task automatic idle(input int n);
      logic q;
      for (int i = 0; i < n; i++)
         tick(1'b0, ~tdi, q);
   endtask
   // one instruction or data scan, lsb first, from idle back to idle
   task automatic scan(input logic ir, input int len, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      tick(1'b1, ~tdi, q);
      if (ir)
         tick(1'b1, ~tdi, q);
      tick(1'b0, ~tdi, q);
      tick(1'b0, ~tdi, q);
      for (int i = 0; i < len; i++)
      begin
         tick(i == len - 1, din[i], q);
         dout[i] = q;
      end
      tick(1'b1, ~tdi, q);
      tick(1'b0, ~tdi, q);
   endtask
endmodule // jisp_prog

// ==== jisp_tap.sv ====
`timescale 1ns/1ps
// test access port controller on the test clock
module jisp_tap #(parameter int AW = 5, parameter int DW = 16,
   parameter logic [31:0] ID_CODE = 32'h0ABC_D001) // arbitrary value
(
   input wire logic tck,
   input wire logic resetn,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   jisp_xfer_if.link xf
);
   typedef enum logic [15:0] {
      T_RESET = 16'h0001, T_IDLE = 16'h0002, T_SELDR = 16'h0004, T_CAPDR = 16'h0008,
      T_SHDR = 16'h0010, T_EX1DR = 16'h0020, T_PADR = 16'h0040, T_EX2DR = 16'h0080,
      T_UPDR = 16'h0100, T_SELIR = 16'h0200, T_CAPIR = 16'h0400, T_SHIR = 16'h0800,
      T_EX1IR = 16'h1000, T_PAIR = 16'h2000, T_EX2IR = 16'h4000, T_UPIR = 16'h8000
   } jisp_tap_t;
   typedef struct packed {
      jisp_tap_t ts;
      logic [3:0] ir, ir_sh;
      logic [31:0] dr;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic [jisp_pkg::OP_W-1:0] op;
      logic req_tgl, ack_s1, ack_s2;
      logic [2:0] st_s1, st_s2;
      logic tdo, tdo_oe_n;
   } jisp_tap_st_t;
   jisp_tap_st_t q_r, q_nxt;
   logic busy;

   // an operation is outstanding until its acknowledge toggle comes back
   assign busy = q_r.req_tgl != q_r.ack_s2;

   // state walk, registers and operation launch
   always_comb
   begin
      q_nxt = q_r;
      q_nxt.ack_s1 = xf.ack_tgl;
      q_nxt.ack_s2 = q_r.ack_s1;
      q_nxt.st_s1 = {xf.refused, xf.done, xf.isp_ready};
      q_nxt.st_s2 = q_r.st_s1;
      unique case (q_r.ts)
         T_RESET: q_nxt.ts = tms ? T_RESET : T_IDLE;
         T_IDLE: q_nxt.ts = tms ? T_SELDR : T_IDLE;
         T_SELDR: q_nxt.ts = tms ? T_SELIR : T_CAPDR;
         T_CAPDR: q_nxt.ts = tms ? T_EX1DR : T_SHDR;
         T_SHDR: q_nxt.ts = tms ? T_EX1DR : T_SHDR;
         T_EX1DR: q_nxt.ts = tms ? T_UPDR : T_PADR;
         T_PADR: q_nxt.ts = tms ? T_EX2DR : T_PADR;
         T_EX2DR: q_nxt.ts = tms ? T_UPDR : T_SHDR;
         T_UPDR: q_nxt.ts = tms ? T_SELDR : T_IDLE;
         T_SELIR: q_nxt.ts = tms ? T_RESET : T_CAPIR;
         T_CAPIR: q_nxt.ts = tms ? T_EX1IR : T_SHIR;
         T_SHIR: q_nxt.ts = tms ? T_EX1IR : T_SHIR;
         T_EX1IR: q_nxt.ts = tms ? T_UPIR : T_PAIR;
         T_PAIR: q_nxt.ts = tms ? T_EX2IR : T_PAIR;
         T_EX2IR: q_nxt.ts = tms ? T_UPIR : T_SHIR;
         T_UPIR: q_nxt.ts = tms ? T_SELDR : T_IDLE;
         default: q_nxt.ts = T_RESET;
      endcase
      if (q_r.ts == T_RESET)
         q_nxt.ir = jisp_pkg::IR_IDCODE;
      if (q_r.ts == T_CAPIR)
         q_nxt.ir_sh = jisp_pkg::IR_CAPT;
      if (q_r.ts == T_SHIR)
         q_nxt.ir_sh = {tdi, q_r.ir_sh[3:1]};
      if (q_r.ts == T_UPIR)
      begin
         q_nxt.ir = q_r.ir_sh;
         if (!busy)
         begin
            case (q_r.ir_sh)
               jisp_pkg::IR_ENTER: q_nxt.op = jisp_pkg::OP_ENTER;
               jisp_pkg::IR_EXIT: q_nxt.op = jisp_pkg::OP_EXIT;
               jisp_pkg::IR_ERASE: q_nxt.op = jisp_pkg::OP_ERASE;
               jisp_pkg::IR_PROG: q_nxt.op = jisp_pkg::OP_PROG;
               jisp_pkg::IR_VERIFY: q_nxt.op = jisp_pkg::OP_READ;
               default: ;
            endcase
            if (q_r.ir_sh >= jisp_pkg::IR_ENTER && q_r.ir_sh <= jisp_pkg::IR_VERIFY)
               q_nxt.req_tgl = ~q_r.req_tgl;
         end
      end
      if (q_r.ts == T_CAPDR)
      begin
         case (q_r.ir)
            jisp_pkg::IR_IDCODE: q_nxt.dr = ID_CODE;
            jisp_pkg::IR_ADDR: q_nxt.dr = 32'(q_r.addr);
            jisp_pkg::IR_DATA: q_nxt.dr = 32'(xf.rdata);
            jisp_pkg::IR_STATUS: q_nxt.dr = 32'({q_r.st_s2, busy});
            default: q_nxt.dr = 32'h0000_0000;
         endcase
      end
      if (q_r.ts == T_SHDR)
         q_nxt.dr = {tdi, q_r.dr[31:1]};
      if (q_r.ts == T_UPDR && !busy)
      begin
         if (q_r.ir == jisp_pkg::IR_ADDR)
            q_nxt.addr = q_r.dr[31 -: AW];
         if (q_r.ir == jisp_pkg::IR_DATA)
            q_nxt.wdata = q_r.dr[31 -: DW];
      end
      // serial output follows the shift stage
      q_nxt.tdo = (q_nxt.ts == T_SHIR) ? q_nxt.ir_sh[0] : q_nxt.dr[0];
      q_nxt.tdo_oe_n = !(q_nxt.ts == T_SHDR || q_nxt.ts == T_SHIR);
   end

   always_ff @(posedge tck or negedge resetn)
   begin
      if (!resetn)
         q_r <= '{ts: T_RESET, ir: jisp_pkg::IR_IDCODE, tdo_oe_n: 1'b1, default: '0};
      else
         q_r <= q_nxt;
   end

   assign tdo = q_r.tdo;
   assign tdo_oe_n = q_r.tdo_oe_n;
   assign xf.req_tgl = q_r.req_tgl;
   assign xf.op = q_r.op;
   assign xf.addr = q_r.addr;
   assign xf.wdata = q_r.wdata;
endmodule // jisp_tap

// ==== jisp_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module testbench;
   localparam int PINS = 8;
   localparam logic [31:0] ID_EXP = 32'h0ABC_D001; // arbitrary value
   logic mclk, resetn, tck, tms, tdi, tdo, tdo_oe_n, isp_active, prog_complete;
   logic [PINS-1:0] user_out, mc_oe, pin_in, pin_out, pin_oe_n, pin_pullup;
   logic [1:0] goe_in;
   logic [31:0] d;
   int bad_count, num_checks;
   jisp_top #(.PINS(PINS), .T_ENTER_CYC(20), .T_EXIT_CYC(20), .T_ERASE_CYC(40)) i_jisp_top (.mclk(mclk),
      .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .user_out(user_out),
      .mc_oe(mc_oe), .goe_in(goe_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup(pin_pullup), .isp_active(isp_active), .prog_complete(prog_complete));
   jisp_prog i_jisp_prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
   // core clock
   always #2 mclk = ~mclk;
   task automatic stop_test();
      if (bad_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // poll status until busy clears
   task automatic poll();
      int n;
      n = 0;
      i_jisp_prog.scan(1'b1, 4, {28'h0, jisp_pkg::IR_STATUS}, d);
      do
      begin
         i_jisp_prog.scan(1'b0, 4, 32'h0, d);
         n++;
      end
      while (d[0] !== 1'b0 && n < 300);
      if (n >= 300)
      begin
         bad_count++;
         stop_test();
      end
   endtask
   task automatic op(input logic [3:0] code);
      i_jisp_prog.scan(1'b1, 4, {28'h0, code}, d);
      poll();
   endtask
   task automatic set_addr(input logic [4:0] a);
      i_jisp_prog.scan(1'b1, 4, {28'h0, jisp_pkg::IR_ADDR}, d);
      i_jisp_prog.scan(1'b0, 5, {27'h0, a}, d);
   endtask
   task automatic prog_word(input logic [4:0] a, input logic [15:0] w);
      set_addr(a);
      i_jisp_prog.scan(1'b1, 4, {28'h0, jisp_pkg::IR_DATA}, d);
      i_jisp_prog.scan(1'b0, 16, {16'h0, w}, d);
      op(jisp_pkg::IR_PROG);
   endtask
   task automatic verify_word(input logic [4:0] a, input logic [15:0] m, input logic [15:0] w);
      set_addr(a);
      op(jisp_pkg::IR_VERIFY);
      i_jisp_prog.scan(1'b1, 4, {28'h0, jisp_pkg::IR_DATA}, d);
      i_jisp_prog.scan(1'b0, 16, 32'h0, d);
      `CHK(d[15:0] & m, w)
   endtask
   // identity read after reset, instruction capture value, idle output enable
   task automatic t_id();
      i_jisp_prog.scan(1'b0, 32, 32'h0, d);
      `CHK(d, ID_EXP)
      i_jisp_prog.scan(1'b1, 4, {28'h0, jisp_pkg::IR_IDCODE}, d);
      `CHK(d[3:0], 4'h1)
      `CHK(tdo_oe_n, 1'b1)
   endtask
   // programming out of order is refused in user mode
   task automatic t_refuse();
      op(jisp_pkg::IR_PROG);
      `CHK(d[3], 1'b1)
      `CHK(isp_active, 1'b0)
   endtask
   // adaptive entry: poll until ready, then check the pin state
   task automatic t_enter(input logic done);
      op(jisp_pkg::IR_ENTER);
      `CHK(d[3:0], {1'b0, done, 2'b10})
      @(negedge mclk);
      `CHK(pin_oe_n, 8'hFF)
      `CHK(pin_pullup, 8'hFF)
      i_jisp_prog.scan(1'b1, 4, {28'h0, jisp_pkg::IR_IDCODE}, d);
      t_id();
   endtask
   task automatic t_exit();
      op(jisp_pkg::IR_EXIT);
      repeat (8) @(negedge mclk);
      `CHK(isp_active, 1'b0)
      `CHK(pin_pullup, 8'h00)
   endtask
   // full run without the complete bit leaves pins safe
   task automatic t_run_partial();
      t_enter(1'b0);
      i_jisp_prog.scan(1'b1, 4, {28'h0, jisp_pkg::IR_ERASE}, d);
      i_jisp_prog.idle(20);
      poll();
      verify_word(5'h00, 16'hFFFF, 16'hFFFF);
      prog_word(5'h00, 16'h0001);
      prog_word(5'h02, 16'h0002);
      prog_word(5'h03, 16'h0006);
      prog_word(5'h08, 16'h0000);
      prog_word(5'h09, 16'h0002);
      t_exit();
      `CHK(prog_complete, 1'b0)
      `CHK(pin_oe_n, 8'hFF)
   endtask
   // second run sets the complete bit; user mode enables then follow the cells
   task automatic t_run_complete();
      t_enter(1'b0);
      prog_word(5'd14, 16'h0001);
      verify_word(5'h00, 16'hFFFF, 16'h0001);
      verify_word(5'h05, 16'hFFFF, 16'hFFFF);
      verify_word(5'd14, 16'h0001, 16'h0001);
      t_exit();
      `CHK(prog_complete, 1'b1)
      `CHK(pin_oe_n, 8'hFA)
      `CHK(pin_out, user_out)
      goe_in = 2'h0;
      repeat (6) @(negedge mclk);
      `CHK(pin_oe_n, 8'hF6)
   endtask
   // stand-alone verify: enter, identity, verify, exit; a second enter is refused
   task automatic t_verify_only();
      t_enter(1'b1);
      op(jisp_pkg::IR_ENTER);
      `CHK(d[3:0], 4'hE)
      verify_word(5'h03, 16'hFFFF, 16'h0006);
      verify_word(5'd14, 16'h0001, 16'h0001);
      t_exit();
      `CHK(pin_oe_n, 8'hF6)
   endtask
   initial
   begin
      mclk = 1'b0;
      resetn = 1'b0;
      user_out = 8'hA5;
      mc_oe = 8'h00;
      pin_in = 8'h00;
      goe_in = 2'h1;
      bad_count = 0;
      num_checks = 0;
      repeat (6) @(negedge mclk);
      resetn = 1'b1;
      i_jisp_prog.reset_tap();
      t_id();
      t_refuse();
      t_run_partial();
      @(negedge mclk);
      t_run_complete();
      t_verify_only();
      stop_test();
   end
endmodule // testbench
bind jisp_top jisp_chk #(.PINS(PINS)) i_jisp_chk (.mclk(mclk), .resetn(resetn), .tck(tck), .tms(tms),
   .tdo_oe_n(tdo_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup),
   .isp_active(isp_active), .prog_complete(prog_complete));

// ==== jisp_top.sv ====
`timescale 1ns/1ps
// in-system programming sequencer and pin gating
module jisp_top #(
   parameter int PINS = 8,
   parameter int NGOE = 6,
   parameter int DW = 16,
   parameter int AW = 5,
   parameter int unsigned T_ENTER_CYC = jisp_pkg::ENTER_CYC,
   parameter int unsigned T_EXIT_CYC = jisp_pkg::EXIT_CYC,
   parameter int unsigned T_ERASE_CYC = jisp_pkg::ERASE_CYC
)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   input wire logic [PINS-1:0] user_out,
   input wire logic [PINS-1:0] mc_oe,
   input wire logic [1:0] goe_in,
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe_n,
   output logic [PINS-1:0] pin_pullup,
   output logic isp_active,
   output logic prog_complete
);
   localparam int DEPTH = PINS + NGOE;
   localparam int NSRC = 4 + 2 * PINS;

   typedef enum logic [6:0] {
      S_USER = 7'h01,
      S_ENTER = 7'h02,
      S_ISP = 7'h04,
      S_ERASE = 7'h08,
      S_PROG = 7'h10,
      S_READ = 7'h20,
      S_EXIT = 7'h40
   } jisp_seq_t;

   typedef struct packed {
      jisp_seq_t st;
      logic [jisp_pkg::TMR_W-1:0] tmr;
      logic rq_s1;
      logic rq_s2;
      logic rq_s3;
      logic ack_tgl;
      logic [jisp_pkg::OP_W-1:0] op;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic [DW-1:0] rdata;
      logic pgm_en;
      logic ers_en;
      logic isp_ready;
      logic refused;
      logic [1:0] goe_s1;
      logic [1:0] goe_s2;
      logic [PINS-1:0] pin_s1;
      logic [PINS-1:0] pin_s2;
      logic [PINS-1:0] pin_out;
      logic [PINS-1:0] pin_oe_n;
      logic [PINS-1:0] pin_pull;
      logic isp_active;
      logic prog_complete;
   } jisp_top_st_t;

   jisp_top_st_t q_r, q_nxt;
   logic [DEPTH-1:0][DW-1:0] mem_q;
   logic done_q;
   logic new_req;
   logic [DW-1:0] rd_word;
   logic [31:0] src_pad;
   logic [15:0] goe_pad;
   logic [NGOE-1:0] goe;
   logic [PINS-1:0] pin_en;

   jisp_xfer_if #(.AW(AW), .DW(DW)) xf ();

   // test port on its own clock
   jisp_tap #(.AW(AW), .DW(DW)) u_tap (
      .tck(tck),
      .resetn(resetn),
      .tms(tms),
      .tdi(tdi),
      .tdo(tdo),
      .tdo_oe_n(tdo_oe_n),
      .xf(xf.link)
   );

   // the cells that hold the pin setup and the complete bit
   jisp_cells #(.AW(AW), .DW(DW), .DEPTH(DEPTH)) u_cells (
      .mclk(mclk),
      .resetn(resetn),
      .pgm_en(q_r.pgm_en),
      .ers_en(q_r.ers_en),
      .addr(q_r.addr),
      .wdata(q_r.wdata),
      .mem_q(mem_q),
      .done_q(done_q)
   );

   // answers back to the test clock side, all stable flops
   assign xf.ack_tgl = q_r.ack_tgl;
   assign xf.rdata = q_r.rdata;
   assign xf.isp_ready = q_r.isp_ready;
   assign xf.done = q_r.prog_complete;
   assign xf.refused = q_r.refused;

   // a request is seen on the synced toggle, never on its first stage
   assign new_req = q_r.rq_s2 ^ q_r.rq_s3;

   // word read by a verify pulse; the word above the array is the complete bit
   always_comb
   begin
      rd_word = '0;
      if (q_r.addr < AW'(DEPTH))
         rd_word = mem_q[q_r.addr];
      else if (q_r.addr == AW'(DEPTH))
         rd_word = DW'(done_q);
   end

   // enable sources: both polarities of the two enable pins, pins, macrocells
   assign src_pad = 32'({mc_oe, q_r.pin_s2, ~q_r.goe_s2, q_r.goe_s2});

   // each global enable picks one source by its cell word
   genvar gk;
   generate
      for (gk = 0; gk < NGOE; gk++)
      begin : g_goe
         logic [jisp_pkg::GS_W-1:0] sel;
         assign sel = mem_q[PINS + gk][jisp_pkg::GS_LO +: jisp_pkg::GS_W];
         assign goe[gk] = (32'(sel) < NSRC) ? src_pad[sel] : 1'b0;
      end
   endgenerate

   assign goe_pad = 16'(goe);

   // each pin: grounded control floats it, tied-high keeps it on, or global enable
   genvar gp;
   generate
      for (gp = 0; gp < PINS; gp++)
      begin : g_pin
         logic [jisp_pkg::PM_W-1:0] mode;
         logic [jisp_pkg::PG_W-1:0] gi;
         assign mode = mem_q[gp][jisp_pkg::PM_LO +: jisp_pkg::PM_W];
         assign gi = mem_q[gp][jisp_pkg::PG_LO +: jisp_pkg::PG_W];
         assign pin_en[gp] = (mode == jisp_pkg::PM_VCC) ||
            (mode == jisp_pkg::PM_GLB && 32'(gi) < NGOE && goe_pad[gi]);
      end
   endgenerate

   // sequencer: mode, pulses, handshake and pin drive
   always_comb
   begin
      q_nxt = q_r;
      q_nxt.pgm_en = 1'b0;
      q_nxt.ers_en = 1'b0;

      // synchronisers for the request toggle and the input pins
      q_nxt.rq_s1 = xf.req_tgl;
      q_nxt.rq_s2 = q_r.rq_s1;
      q_nxt.rq_s3 = q_r.rq_s2;
      q_nxt.goe_s1 = goe_in;
      q_nxt.goe_s2 = q_r.goe_s1;
      q_nxt.pin_s1 = pin_in;
      q_nxt.pin_s2 = q_r.pin_s1;
      q_nxt.prog_complete = done_q;

      // operation fields are stable while the toggle is in flight
      if (new_req)
      begin
         q_nxt.op = xf.op;
         q_nxt.addr = xf.addr;
         q_nxt.wdata = xf.wdata;
      end

      unique case (q_r.st)
         S_USER:
         begin
            if (new_req)
            begin
               if (xf.op == jisp_pkg::OP_ENTER)
               begin
                  q_nxt.st = S_ENTER;
                  q_nxt.tmr = jisp_pkg::TMR_W'(T_ENTER_CYC - 1);
                  q_nxt.isp_active = 1'b1;
                  q_nxt.refused = 1'b0;
               end
               else
               begin
                  q_nxt.refused = 1'b1;
                  q_nxt.ack_tgl = ~q_r.ack_tgl;
               end
            end
         end
         S_ENTER:
         begin
            if (q_r.tmr == '0)
            begin
               q_nxt.st = S_ISP;
               q_nxt.isp_ready = 1'b1;
               q_nxt.ack_tgl = ~q_r.ack_tgl;
            end
            else
               q_nxt.tmr = q_r.tmr - 1'b1;
         end
         S_ISP:
         begin
            if (new_req)
            begin
               unique case (xf.op)
                  jisp_pkg::OP_ERASE:
                  begin
                     q_nxt.st = S_ERASE;
                     q_nxt.tmr = jisp_pkg::TMR_W'(T_ERASE_CYC - 1);
                  end
                  jisp_pkg::OP_PROG:
                  begin
                     q_nxt.st = S_PROG;
                     q_nxt.tmr = jisp_pkg::TMR_W'(jisp_pkg::PROG_CYC - 1);
                  end
                  jisp_pkg::OP_READ:
                  begin
                     q_nxt.st = S_READ;
                     q_nxt.tmr = jisp_pkg::TMR_W'(jisp_pkg::READ_CYC - 1);
                  end
                  jisp_pkg::OP_EXIT:
                  begin
                     q_nxt.st = S_EXIT;
                     q_nxt.isp_ready = 1'b0;
                     q_nxt.tmr = jisp_pkg::TMR_W'(T_EXIT_CYC - 1);
                  end
                  default:
                  begin
                     q_nxt.refused = 1'b1;
                     q_nxt.ack_tgl = ~q_r.ack_tgl;
                  end
               endcase
            end
         end
         S_ERASE:
         begin
            if (q_r.tmr == '0)
            begin
               q_nxt.ers_en = 1'b1;
               q_nxt.st = S_ISP;
               q_nxt.ack_tgl = ~q_r.ack_tgl;
            end
            else
               q_nxt.tmr = q_r.tmr - 1'b1;
         end
         S_PROG:
         begin
            if (q_r.tmr == '0)
            begin
               q_nxt.pgm_en = 1'b1;
               q_nxt.st = S_ISP;
               q_nxt.ack_tgl = ~q_r.ack_tgl;
            end
            else
               q_nxt.tmr = q_r.tmr - 1'b1;
         end
         S_READ:
         begin
            if (q_r.tmr == '0)
            begin
               q_nxt.rdata = rd_word;
               q_nxt.st = S_ISP;
               q_nxt.ack_tgl = ~q_r.ack_tgl;
            end
            else
               q_nxt.tmr = q_r.tmr - 1'b1;
         end
         S_EXIT:
         begin
            if (q_r.tmr == '0)
            begin
               q_nxt.st = S_USER;
               q_nxt.isp_active = 1'b0;
               q_nxt.ack_tgl = ~q_r.ack_tgl;
            end
            else
               q_nxt.tmr = q_r.tmr - 1'b1;
         end
         default:
         begin
            q_nxt.st = S_USER;
            q_nxt.isp_active = 1'b0;
         end
      endcase

      // pins: drivers follow the new mode, pull-ups the wider of old and new,
      // so a pin is never left floating without its pull-up in either direction
      if (q_nxt.isp_active)
      begin
         q_nxt.pin_oe_n = '1;
         q_nxt.pin_out = '0;
      end
      else
      begin
         q_nxt.pin_out = user_out;
         q_nxt.pin_oe_n = q_r.prog_complete ? ~pin_en : '1;
      end
      q_nxt.pin_pull = (q_nxt.isp_active || q_r.isp_active) ? '1 : '0;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         q_r <= '{st: S_USER, pin_oe_n: '1, default: '0};
      else
         q_r <= q_nxt;
   end

   // outputs straight from the state flops
   assign pin_out = q_r.pin_out;
   assign pin_oe_n = q_r.pin_oe_n;
   assign pin_pullup = q_r.pin_pull;
   assign isp_active = q_r.isp_active;
   assign prog_complete = q_r.prog_complete;
endmodule // jisp_top

// ==== jisp_xfer_if.sv ====
`timescale 1ns/1ps
// operation handshake between the test clock and the core clock
interface jisp_xfer_if #(parameter int AW = 5, parameter int DW = 16);
   logic req_tgl;
   logic [jisp_pkg::OP_W-1:0] op;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic ack_tgl;
   logic [DW-1:0] rdata;
   logic isp_ready;
   logic done;
   logic refused;
   modport link (output req_tgl, op, addr, wdata, input ack_tgl, rdata, isp_ready, done, refused);
   modport core (input req_tgl, op, addr, wdata, output ack_tgl, rdata, isp_ready, done, refused);
endinterface // jisp_xfer_if
